/* File: bench/adcc_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_core_tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk, cs_n, din, dout, dout_oe, chain_out, ready_out_n, crystal_drive;
   logic buffered_clock_out, buffered_clock_oe, mod_clk, conv_valid = 1'b0, conv_ready;
   logic [95:0] conv_data = '0;
   logic [3:0] over_pos = '0;
   logic [3:0] fault_in = '0;
   logic [3:0] over_neg = '0;
   logic [3:0] fault_pos = '0;
   logic range_overflow_n, fault_n, osc_enable_bit, protect_disable_bit, shutdown;
   logic [2:0] rate_select_code;
   logic [31:0] sample_delay;
   logic [15:0] rate_ctrl;
   logic [1:0] ckd = 2'h0;
   logic [95:0] rdv;
   logic mc_q = 1'b0;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int mrise = 0;
   always #10 ref_clk = ~ref_clk;
   always @(negedge ref_clk) ckd <= ckd + 2'h1;
   always @(posedge ref_clk)
   begin
      mc_q <= mod_clk;
      if (mod_clk && !mc_q)
         mrise++;
      cyc++;
      if (cyc == 40000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   adcc_host u_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
      .dout_oe(dout_oe));
   adcc_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .dout_oe(dout_oe), .chain_in(1'b0), .chain_out(chain_out),
      .ready_chain_in_n(1'b0), .ready_out_n(ready_out_n), .clock_in(ckd[1]),
      .crystal_drive(crystal_drive), .buffered_clock_out(buffered_clock_out),
      .buffered_clock_oe(buffered_clock_oe), .mod_clk(mod_clk), .conv_valid(conv_valid),
      .conv_ready(conv_ready), .conv_data(conv_data), .over_pos(over_pos),
      .over_neg(over_neg), .fault_in(fault_in), .fault_pos(fault_pos),
      .range_overflow_n(range_overflow_n), .fault_n(fault_n),
      .osc_enable_bit(osc_enable_bit), .protect_disable_bit(protect_disable_bit),
      .shutdown(shutdown), .rate_select_code(rate_select_code),
      .sample_delay(sample_delay), .rate_ctrl(rate_ctrl));
   task automatic report_and_stop();
      if (n_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic xf(input logic rw, input logic [6:0] a, input logic [95:0] wd,
      input int n, input int ab);
      u_host.xfer({rw, a}, wd, n, ab, rdv);
   endtask
   task automatic push(input logic [95:0] d, input logic [3:0] op);
      int k;
      k = 0;
      @(negedge ref_clk);
      conv_valid = 1'b1;
      conv_data = d;
      over_pos = op;
      while (conv_ready !== 1'b1 && k < 100)
      begin
         @(negedge ref_clk);
         k++;
      end
      @(negedge ref_clk);
      conv_valid = 1'b0;
      over_pos = 4'h0;
      repeat (3) @(negedge ref_clk);
   endtask
   task automatic wait_ready();
      int k;
      k = 0;
      while (ready_out_n !== 1'b0 && k < 20)
      begin
         @(negedge ref_clk);
         k++;
      end
   endtask
   task automatic rd_dat();
      xf(adcc_pkg::RW_READ, adcc_pkg::ADDR_DAT, '0, 96, 96);
   endtask
   localparam logic [95:0] DW = 96'h123456_0ABCDE_654321_0FEDCB;
   initial
   begin
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk({sample_delay, rate_ctrl, osc_enable_bit, protect_disable_bit, shutdown}, '0);
      chk({range_overflow_n, fault_n, ready_out_n, dout_oe, buffered_clock_oe}, 5'h1C);
      xf(adcc_pkg::RW_WRITE, adcc_pkg::ADDR_CFG, {8'h18, 88'h0}, 8, 8);
      chk({osc_enable_bit, protect_disable_bit, buffered_clock_oe}, 3'h7);
      chk({buffered_clock_out, crystal_drive}, {ckd[1], ~ckd[1]});
      repeat (2) @(negedge ref_clk);
      chk({buffered_clock_out, crystal_drive}, {ckd[1], ~ckd[1]});
      xf(adcc_pkg::RW_WRITE, adcc_pkg::ADDR_DRC, {16'hE001, 80'h0}, 16, 16);
      chk({rate_select_code, rate_ctrl}, {3'h7, 16'hE001});
      xf(adcc_pkg::RW_WRITE, adcc_pkg::ADDR_SIC, {32'hA5C31E7F, 64'h0}, 32, 32);
      chk(sample_delay, 32'hA5C31E7F);
      xf(adcc_pkg::RW_READ, adcc_pkg::ADDR_SIC, '0, 32, 32);
      chk(rdv[95:64], 32'hA5C31E7F);
      xf(adcc_pkg::RW_READ, adcc_pkg::ADDR_DRC, '0, 16, 16);
      chk(rdv[95:80], 16'hE001);
      xf(adcc_pkg::RW_WRITE, adcc_pkg::ADDR_SIC, {32'h12345678, 64'h0}, 32, 31);
      chk(sample_delay, 32'hA5C31E7F);
      chk(dout_oe, 1'b0);
      mrise = 0;
      repeat (256) @(negedge ref_clk);
      chk(mrise, 8);
      xf(adcc_pkg::RW_WRITE, adcc_pkg::ADDR_DRC, '0, 16, 16);
      xf(adcc_pkg::RW_WRITE, adcc_pkg::ADDR_CFG, '0, 8, 8);
      chk(buffered_clock_oe, 1'b0);
      push(DW, 4'b0010);
      wait_ready();
      chk({ready_out_n, range_overflow_n}, 2'h0);
      rd_dat();
      chk(rdv, {DW[95:72], adcc_pkg::FS_POS, DW[47:0]});
      fault_in = 4'b0100;
      repeat (3) @(negedge ref_clk);
      chk(fault_n, 1'b0);
      rd_dat();
      chk(rdv[47:0], {adcc_pkg::FS_NEG, DW[23:0]});
      fault_in = 4'h0;
      repeat (20) push(DW, 4'h0);
      chk(fault_n, 1'b0);
      rd_dat();
      chk(rdv, {DW[95:48], adcc_pkg::FS_NEG, DW[23:0]});
      repeat (5) push(DW, 4'h0);
      chk({fault_n, range_overflow_n}, 2'h3);
      fault_pos = 4'b0001;
      fault_in = 4'b0001;
      repeat (3) @(negedge ref_clk);
      chk({fault_n, range_overflow_n}, 2'h0);
      rd_dat();
      chk(rdv[95:72], adcc_pkg::FS_POS);
      fault_in = 4'h0;
      over_neg = 4'b1000;
      push(DW, 4'h0);
      over_neg = 4'h0;
      rd_dat();
      chk(rdv, {adcc_pkg::FS_POS, DW[71:24], adcc_pkg::FS_NEG});
      xf(adcc_pkg::RW_WRITE, adcc_pkg::ADDR_CFG, {8'h08, 88'h0}, 8, 8);
      fault_in = 4'b0100;
      repeat (3) @(negedge ref_clk);
      chk(fault_n, 1'b1);
      push(~DW, 4'h0);
      rd_dat();
      chk(rdv, ~DW);
      fault_in = 4'h0;
      u_host.hold(1'b0);
      push(DW, 4'h0);
      push(~DW, 4'h0);
      chk(conv_ready, 1'b0);
      u_host.hold(1'b1);
      repeat (10) @(negedge ref_clk);
      chk({conv_ready, ready_out_n}, 2'h2);
      rd_dat();
      chk(rdv, ~DW);
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: bench/adcc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_host (
   input wire logic ref_clk, // System clock
   output logic sclk, // Serial clock
   output logic cs_n, // Chip select
   output logic din, // Serial data to device
   input wire logic dout, // Serial data from device
   input wire logic dout_oe // Device drives dout
);
   initial
   begin
      sclk = 1'b1; // Idle high
      cs_n = 1'b1;
      din = 1'b0;
   end
   task automatic half();
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic hold(input logic v);
      @(negedge ref_clk);
      cs_n = v;
   endtask
   // Command then n bits, both left aligned; stops after ab data bits if ab < n
   task automatic xfer(input logic [7:0] cmd, input logic [95:0] wd, input int n,
      input int ab, output logic [95:0] rd);
      logic [103:0] sh;
      sh = {cmd, wd};
      rd = '0;
      hold(1'b0);
      half();
      for (int i = 0; i < 8 + n && i < 8 + ab; i++)
      begin
         if (i >= 8)
            rd[103 - i] = dout_oe ? dout : 1'bx; // Taken before the fall
         din = sh[103 - i]; // MSB first
         sclk = 1'b0;
         half();
         sclk = 1'b1;
         half();
      end
      cs_n = 1'b1;
      din = ~din; // Released line must not keep its last value
      half();
   endtask
endmodule
`default_nettype wire

/* File: core/adcc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_core #(
   parameter int CH_N = 4,
   parameter int REC_N = adcc_pkg::REC_PERIODS
) (
   input wire logic ref_clk, // System clock, 50 MHz
   input wire logic rst_n, // Synchronous reset
   input wire logic sclk, // Serial clock, idle high
   input wire logic cs_n, // Chip select
   input wire logic din, // Serial data in
   output logic dout, // Serial data out
   output logic dout_oe, // Serial output drive enable
   input wire logic chain_in, // Data from next device in chain
   output logic chain_out, // Data passed along the chain
   input wire logic ready_chain_in_n, // Ready from downstream device
   output logic ready_out_n, // New data ready
   input wire logic clock_in, // Crystal or external clock pin
   output logic crystal_drive, // Crystal amplifier output
   output logic buffered_clock_out, // Buffered clock
   output logic buffered_clock_oe, // Buffered clock drive enable
   output logic mod_clk, // Modulator clock
   input wire logic conv_valid, // Conversion result offered
   output logic conv_ready, // Buffer can take a result
   input wire logic [95:0] conv_data, // Four raw results, channel 0 high
   input wire logic [3:0] over_pos, // Result above full scale
   input wire logic [3:0] over_neg, // Result below full scale
   input wire logic [3:0] fault_in, // Input outside fault window
   input wire logic [3:0] fault_pos, // Fault polarity, 1 positive
   output logic range_overflow_n, // Overflow flag
   output logic fault_n, // Fault flag
   output logic osc_enable_bit, // Oscillator enable
   output logic protect_disable_bit, // Protection disable
   output logic shutdown, // Shutdown request
   output logic [2:0] rate_select_code, // Rate code
   output logic [31:0] sample_delay, // Sampling instant control
   output logic [15:0] rate_ctrl // Data-rate control word
);
   if (CH_N != 4) begin : g_bad_ch
      $error("adcc_core serves exactly four channels");
   end
   if (REC_N <= 20 || REC_N >= 24) begin : g_bad_rec
      $error("adcc_core recovery count must lie in 21..23");
   end

   localparam int RW = $clog2(REC_N + 1);

   logic [31:0] sic_r;
   logic [15:0] drc_r;
   logic [7:0] cfg_r;
   logic [23:0] dat_r [4];
   adcc_pkg::adcc_spi_e st_r;
   logic [6:0] cnt_r;
   logic [31:0] rx_r;
   logic [7:0] cmd_r;
   logic [95:0] tx_r;
   logic sclk_prev_r;
   logic s_fall;
   logic s_rise;
   logic [6:0] dlen;
   logic wr_commit;
   logic dat_read;
   logic osc_on;
   logic prot_on;

   assign s_fall = sclk_prev_r & ~sclk;
   assign s_rise = ~sclk_prev_r & sclk;
   // Registers live in ref_clk already, so conversion logic reads them directly
   assign osc_on = cfg_r[adcc_pkg::CFG_OSC_BIT] & ~cfg_r[adcc_pkg::CFG_SHDN_BIT];
   assign prot_on = ~cfg_r[adcc_pkg::CFG_PDIS_BIT] & ~cfg_r[adcc_pkg::CFG_SHDN_BIT];

   always_comb
   begin
      case (cmd_r[6:0])
         adcc_pkg::ADDR_SIC: dlen = 7'(adcc_pkg::SIC_W);
         adcc_pkg::ADDR_DRC: dlen = 7'(adcc_pkg::DRC_W);
         adcc_pkg::ADDR_CFG: dlen = 7'(adcc_pkg::CFG_W);
         default: dlen = 7'(adcc_pkg::DAT_W);
      endcase
   end

   // Write lands on the rising edge after its last bit; abort never gets here
   assign wr_commit = (st_r == adcc_pkg::SP_DONE) && s_rise && !cs_n
      && (cmd_r[7] == adcc_pkg::RW_WRITE);
   assign dat_read = (st_r == adcc_pkg::SP_CMD) && s_fall && (cnt_r == 7'd7)
      && (rx_r[5:0] == adcc_pkg::ADDR_DAT[6:1]) && (din == adcc_pkg::ADDR_DAT[0])
      && (rx_r[6] == adcc_pkg::RW_READ);

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         sclk_prev_r <= 1'b1; // Idle high, so no false edge after reset
      else
         sclk_prev_r <= sclk;
   end

   // Serial sequencer: command byte, data bits, commit
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || cs_n)
      begin
         st_r <= adcc_pkg::SP_IDLE;
         cnt_r <= 7'h00;
         rx_r <= 32'h00000000;
         cmd_r <= 8'h00;
      end
      else
      begin
         case (st_r)
            adcc_pkg::SP_IDLE:
               st_r <= adcc_pkg::SP_CMD;
            adcc_pkg::SP_CMD:
               if (s_fall)
               begin
                  rx_r <= {rx_r[30:0], din};
                  cnt_r <= cnt_r + 7'h01;
                  if (cnt_r == 7'd7)
                  begin
                     cmd_r <= {rx_r[6:0], din};
                     cnt_r <= 7'h00;
                     st_r <= adcc_pkg::SP_DATA;
                  end
               end
            adcc_pkg::SP_DATA:
               if (s_fall)
               begin
                  rx_r <= {rx_r[30:0], din};
                  cnt_r <= cnt_r + 7'h01;
                  if (cnt_r == dlen - 7'h01)
                     st_r <= adcc_pkg::SP_DONE;
               end
            adcc_pkg::SP_DONE:
               if (s_rise)
                  st_r <= adcc_pkg::SP_SPENT;
            adcc_pkg::SP_SPENT:
               st_r <= adcc_pkg::SP_SPENT;
            default:
               st_r <= adcc_pkg::SP_IDLE;
         endcase
      end
   end

   // Control registers
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sic_r <= adcc_pkg::SIC_RST;
         drc_r <= adcc_pkg::DRC_RST;
         cfg_r <= adcc_pkg::CFG_RST;
      end
      else if (wr_commit)
      begin
         case (cmd_r[6:0])
            adcc_pkg::ADDR_SIC: sic_r <= rx_r;
            adcc_pkg::ADDR_DRC: drc_r <= rx_r[15:0];
            adcc_pkg::ADDR_CFG:
               if (rx_r[adcc_pkg::CFG_RST_BIT])
               begin
                  // Soft reset returns every control register to default, itself included
                  sic_r <= adcc_pkg::SIC_RST;
                  drc_r <= adcc_pkg::DRC_RST;
                  cfg_r <= adcc_pkg::CFG_RST;
               end
               else
                  cfg_r <= rx_r[7:0];
            default: cfg_r <= cfg_r;
         endcase
      end
   end

   // Read shifter: our bits first, then whatever the chain feeds behind them
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || cs_n)
      begin
         tx_r <= 96'h0;
         dout <= 1'b0;
      end
      else if (st_r == adcc_pkg::SP_CMD && s_fall && cnt_r == 7'd7)
      begin
         case ({rx_r[6:0], din})
            {adcc_pkg::RW_READ, adcc_pkg::ADDR_SIC}: tx_r <= {sic_r, 64'h0};
            {adcc_pkg::RW_READ, adcc_pkg::ADDR_DRC}: tx_r <= {drc_r, 80'h0};
            {adcc_pkg::RW_READ, adcc_pkg::ADDR_CFG}: tx_r <= {cfg_r, 88'h0};
            {adcc_pkg::RW_READ, adcc_pkg::ADDR_DAT}:
               tx_r <= {dat_r[0], dat_r[1], dat_r[2], dat_r[3]};
            default: tx_r <= 96'h0;
         endcase
      end
      else if (st_r != adcc_pkg::SP_CMD && st_r != adcc_pkg::SP_IDLE && s_rise)
      begin
         dout <= tx_r[95];
         tx_r <= {tx_r[94:0], chain_in};
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         dout_oe <= 1'b0;
         chain_out <= 1'b0;
      end
      else
      begin
         dout_oe <= ~cs_n;
         chain_out <= ~cs_n & din;
      end
   end

   // Clock source and modulator divider
   logic clk_prev_r;
   logic clk_rise;
   logic [1:0] div_r;
   logic [5:0] idle_r;
   logic clk_ok_r;
   assign clk_rise = clock_in & ~clk_prev_r;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         clk_prev_r <= 1'b0;
         div_r <= 2'h0;
         mod_clk <= 1'b0;
      end
      else
      begin
         clk_prev_r <= clock_in;
         if (clk_rise)
         begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'(adcc_pkg::MOD_DIV / 2 - 1))
               mod_clk <= ~mod_clk;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         crystal_drive <= 1'b0;
         buffered_clock_out <= 1'b0;
         buffered_clock_oe <= 1'b0;
      end
      else
      begin
         crystal_drive <= osc_on & ~clock_in;
         buffered_clock_out <= osc_on & clock_in;
         buffered_clock_oe <= osc_on;
      end
   end

   // A clock counts as present while edges keep coming within the timeout
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         idle_r <= 6'h00;
         clk_ok_r <= 1'b0;
      end
      else if (clk_rise)
      begin
         idle_r <= 6'h00;
         clk_ok_r <= 1'b1;
      end
      else if (idle_r == 6'(adcc_pkg::CLK_TIMEOUT_CYC))
         clk_ok_r <= 1'b0;
      else
         idle_r <= idle_r + 6'h01;
   end

   // Per-channel fault hold and recovery counting
   logic push;
   logic pop;
   logic [3:0] f_act;
   logic [3:0] f_new;
   logic [3:0] hold;
   logic [3:0] hpol_r;
   logic [3:0] fprev_r;
   for (genvar i = 0; i < 4; i++)
   begin : g_ch
      logic [RW-1:0] rec_r;
      assign f_act[i] = fault_in[i] & prot_on;
      assign f_new[i] = f_act[i] & ~fprev_r[i];
      // Turning protection off also ends a pending recovery hold
      assign hold[i] = f_act[i] | (prot_on & (rec_r != '0));
      always_ff @(posedge ref_clk)
      begin
         if (!rst_n)
         begin
            rec_r <= '0;
            hpol_r[i] <= 1'b0;
            fprev_r[i] <= 1'b0;
         end
         else
         begin
            fprev_r[i] <= f_act[i];
            if (f_act[i])
            begin
               rec_r <= RW'(REC_N);
               hpol_r[i] <= fault_pos[i];
            end
            else if (push && rec_r != '0)
               rec_r <= rec_r - RW'(1);
         end
      end
   end

   function automatic logic [23:0] clip(input logic h, input logic hp, input logic op,
      input logic on, input logic [23:0] d);
      if (h)
         clip = hp ? adcc_pkg::FS_POS : adcc_pkg::FS_NEG;
      else if (op)
         clip = adcc_pkg::FS_POS;
      else if (on)
         clip = adcc_pkg::FS_NEG;
      else
         clip = d;
   endfunction

   // Two-entry buffer between filter output and data register
   logic [103:0] buf_r [2];
   logic [1:0] bcnt_r;
   logic wp_r;
   logic rp_r;
   logic [1:0] bcnt_nxt;
   logic [95:0] clipped;
   always_comb
   begin
      for (int c = 0; c < 4; c++)
         clipped[95 - 24 * c -: 24] = clip(hold[c], hpol_r[c], over_pos[c], over_neg[c],
            conv_data[95 - 24 * c -: 24]);
   end
   assign push = conv_valid & conv_ready;
   // Data register is frozen while a transfer is open so a read is never torn
   assign pop = (bcnt_r != 2'h0) && (st_r == adcc_pkg::SP_IDLE) && cs_n;
   assign bcnt_nxt = bcnt_r + {1'b0, push} - {1'b0, pop};

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         bcnt_r <= 2'h0;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         conv_ready <= 1'b0;
         buf_r[0] <= 104'h0;
         buf_r[1] <= 104'h0;
      end
      else
      begin
         bcnt_r <= bcnt_nxt;
         conv_ready <= bcnt_nxt != 2'h2;
         if (push)
         begin
            buf_r[wp_r] <= {(over_pos | over_neg) & ~hold, hold, clipped};
            wp_r <= ~wp_r;
         end
         if (pop)
            rp_r <= ~rp_r;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         for (int c = 0; c < 4; c++)
            dat_r[c] <= 24'h000000;
      end
      else
      begin
         for (int c = 0; c < 4; c++)
         begin
            if (pop)
               dat_r[c] <= buf_r[rp_r][95 - 24 * c -: 24];
            // Early jump: a fresh fault overrides only its own channel
            if (f_new[c] && cs_n)
               dat_r[c] <= fault_pos[c] ? adcc_pkg::FS_POS : adcc_pkg::FS_NEG;
         end
      end
   end

   // Data-ready: falls once per new result, rises when the data is read
   logic rdy_pend_r;
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ready_out_n <= 1'b1;
         rdy_pend_r <= 1'b0;
      end
      else if (pop)
      begin
         ready_out_n <= 1'b1;
         rdy_pend_r <= 1'b1;
      end
      else if (dat_read)
      begin
         ready_out_n <= 1'b1;
         rdy_pend_r <= 1'b0;
      end
      else if (rdy_pend_r && !ready_chain_in_n)
      begin
         ready_out_n <= 1'b0;
         rdy_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         range_overflow_n <= 1'b1;
         fault_n <= 1'b1;
      end
      else
      begin
         fault_n <= ~|hold;
         if (!clk_ok_r)
            range_overflow_n <= 1'b1;
         else if (|f_new)
            range_overflow_n <= 1'b0;
         else if (pop)
            range_overflow_n <= ~|buf_r[rp_r][103:96];
      end
   end

   assign osc_enable_bit = cfg_r[adcc_pkg::CFG_OSC_BIT];
   assign protect_disable_bit = cfg_r[adcc_pkg::CFG_PDIS_BIT];
   assign shutdown = cfg_r[adcc_pkg::CFG_SHDN_BIT];
   assign rate_select_code = drc_r[adcc_pkg::RATE_LSB +: adcc_pkg::RATE_W];
   assign sample_delay = sic_r;
   assign rate_ctrl = drc_r;

   property p_div;
      @(posedge ref_clk) disable iff (!rst_n)
      $changed(mod_clk) |-> $past(clk_rise) && $past(div_r) == 2'h3;
   endproperty
   a_div: assert property (p_div) else $error("modulator clock edge off divide");

   property p_osc_on;
      @(posedge ref_clk) disable iff (!rst_n)
      osc_on |=> buffered_clock_oe && (buffered_clock_out == $past(clock_in));
   endproperty
   a_osc_on: assert property (p_osc_on) else $error("buffered clock not driven");

   property p_osc_off;
      @(posedge ref_clk) disable iff (!rst_n)
      !osc_on |=> !buffered_clock_oe;
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("buffered clock not floated");

   property p_ovf_ready;
      @(posedge ref_clk) disable iff (!rst_n)
      (pop && clk_ok_r && !(|f_new) && |buf_r[rp_r][103:96]) |=> !range_overflow_n
         && ready_out_n;
   endproperty
   a_ovf_ready: assert property (p_ovf_ready) else $error("overflow not with result");

   property p_fault_now;
      @(posedge ref_clk) disable iff (!rst_n)
      |f_act |=> !fault_n;
   endproperty
   a_fault_now: assert property (p_fault_now) else $error("fault flag late");

   property p_fault_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(|f_act) && prot_on |-> (!fault_n [*2]);
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault released early");

   property p_prot_off;
      @(posedge ref_clk) disable iff (!rst_n)
      cfg_r[adcc_pkg::CFG_PDIS_BIT] [*2] |-> fault_n;
   endproperty
   a_prot_off: assert property (p_prot_off) else $error("protection acts while off");

   property p_clk_bad;
      @(posedge ref_clk) disable iff (!rst_n)
      !clk_ok_r |=> range_overflow_n;
   endproperty
   a_clk_bad: assert property (p_clk_bad) else $error("overflow asserted without clock");

   property p_ready;
      @(posedge ref_clk) disable iff (!rst_n)
      (pop && !ready_chain_in_n) ##1 (!ready_chain_in_n && !dat_read && !pop) |=> !ready_out_n;
   endproperty
   a_ready: assert property (p_ready) else $error("ready did not fall");

   property p_oe;
      @(posedge ref_clk) disable iff (!rst_n)
      cs_n |=> !dout_oe ##1 (st_r == adcc_pkg::SP_IDLE || !cs_n);
   endproperty
   a_oe: assert property (p_oe) else $error("serial output driven while deselected");

   property p_commit;
      @(posedge ref_clk) disable iff (!rst_n)
      wr_commit |-> $past(st_r) == adcc_pkg::SP_DONE || $past(st_r) == adcc_pkg::SP_DATA;
   endproperty
   a_commit: assert property (p_commit) else $error("write committed mid transfer");
endmodule
`default_nettype wire

/* File: core/adcc_pkg.sv */
package adcc_pkg;
   // Command byte layout
   localparam int CMD_W = 8;
   localparam int ADDR_W = 7;
   localparam logic RW_READ = 1'b1;
   localparam logic RW_WRITE = 1'b0;
   localparam logic [6:0] ADDR_SIC = 7'h40;
   localparam logic [6:0] ADDR_DRC = 7'h50;
   localparam logic [6:0] ADDR_CFG = 7'h60;
   localparam logic [6:0] ADDR_DAT = 7'h70;
   // Register widths (one device in the chain)
   localparam int SIC_W = 32;
   localparam int DRC_W = 16;
   localparam int CFG_W = 8;
   localparam int DAT_W = 96;
   localparam int CNT_W = 7;
   // Configuration fields
   localparam int CFG_SHDN_BIT = 7;
   localparam int CFG_RST_BIT = 6;
   localparam int CFG_EN24_BIT = 5;
   localparam int CFG_OSC_BIT = 4;
   localparam int CFG_PDIS_BIT = 3;
   localparam int RATE_LSB = 13;
   localparam int RATE_W = 3;
   // Reset values
   localparam logic [31:0] SIC_RST = 32'h00000000;
   localparam logic [15:0] DRC_RST = 16'h0000;
   localparam logic [7:0] CFG_RST = 8'h00;
   // Conversion data
   localparam int CH_W = 24;
   localparam logic [23:0] FS_POS = 24'h7FFFFF;
   localparam logic [23:0] FS_NEG = 24'h800000;
   // Clocking
   localparam int MOD_DIV = 8;
   localparam int REC_PERIODS = 22;
   localparam int CLK_PERIOD_NS = 20;
   localparam int CLK_TIMEOUT_NS = 1000;
   localparam int CLK_TIMEOUT_CYC = CLK_TIMEOUT_NS / CLK_PERIOD_NS;
   // Serial port sequence, Gray coded along the usual path
   typedef enum logic [2:0] {
      SP_IDLE = 3'b000,
      SP_CMD = 3'b001,
      SP_DATA = 3'b011,
      SP_DONE = 3'b010,
      SP_SPENT = 3'b110
   } adcc_spi_e;
endpackage
